// >>> verilog/atc_api_tx_frame_codec.sv
`timescale 1ns/1ps
`default_nettype none
module atc_api_tx_frame_codec (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic frame_ok_o,
  output logic frame_bad_o,
  output logic resp_req_o
);
  // Byte stream from decoder
  atc_byte_if bif ();
  // Software settings
  logic api_escape_mode;
  logic [7:0] max_hop_count;
  logic [7:0] max_payload_size;
  logic [7:0] default_src_endpoint;
  logic [7:0] default_dest_endpoint;
  logic [15:0] default_cluster_id;
  // Payload read pointer and data
  logic [7:0] rd_ptr;
  logic [7:0] next_rd_ptr;
  logic [7:0] mem_q;
  logic [7:0] err_cnt;
  // Receive state
  atc_pkg::atc_state_t state;
  logic [15:0] len;
  logic [15:0] cnt;
  logic [7:0] sum;
  // Fields of the frame in flight
  logic [7:0] w_type;
  logic [7:0] w_id;
  logic [63:0] w_dest;
  logic [7:0] w_sep;
  logic [7:0] w_dep;
  logic [15:0] w_clu;
  logic [15:0] w_prof;
  logic [7:0] w_rad;
  logic [7:0] w_opt;
  logic [7:0] w_plen;
  logic w_err;
  // Last accepted frame
  logic pending;
  logic r_resp;
  logic r_bcast;
  logic r_apply;
  logic [7:0] r_type;
  logic [7:0] r_id;
  logic [63:0] r_dest;
  logic [7:0] r_sep;
  logic [7:0] r_dep;
  logic [15:0] r_clu;
  logic [15:0] r_prof;
  logic [7:0] r_rad;
  logic [7:0] r_opt;
  logic [7:0] r_plen;
  // Decode helpers
  logic take;
  logic restart;
  logic [15:0] off;
  logic [15:0] pl_start;
  logic in_pl;
  logic pl_wr;
  logic csum_ok;
  logic good;
  logic commit;
  logic reject;
  logic bcast;
  logic [7:0] res_rad;
  logic [31:0] stat;
  // Bus helpers
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic release_wr;
  logic [31:0] rd_mux;

  // Escape removal
  atc_esc_decoder u_dec (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .rx_data_i (rx_data_i),
    .rx_valid_i (rx_valid_i),
    .esc_mode_i (api_escape_mode),
    .rx_ready_o (rx_ready_o),
    .out (bif.src)
  );

  // Payload buffer
  atc_pl_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .we_i (pl_wr),
    .waddr_i (w_plen),
    .wdata_i (bif.data),
    .raddr_i (next_rd_ptr),
    .rdata_o (mem_q)
  );

  // Stall input while a result waits for software
  assign bif.ready = !pending;
  assign take = bif.valid && bif.ready;
  // Mid-frame delimiter only restarts in escaped mode
  assign restart = take && bif.sof && (api_escape_mode || state == atc_pkg::S_IDLE);
  assign off = cnt + atc_pkg::OFF_TYPE;

  // Payload start per frame type
  // payload offsets
  assign pl_start = (w_type == atc_pkg::FT_TXREQ) ? atc_pkg::TX_PL :
                    (w_type == atc_pkg::FT_EXPL) ? atc_pkg::EX_PL :
                    (w_type == atc_pkg::FT_REMOTE) ? atc_pkg::RM_PL : atc_pkg::OFF_NONE;
  assign in_pl = take && !restart && state == atc_pkg::S_BODY && off >= pl_start;
  assign pl_wr = in_pl && (w_plen != max_payload_size);

  assign csum_ok = (8'(sum + bif.data) == atc_pkg::CSUM_FULL);
  assign good = csum_ok && !w_err;
  assign commit = take && !restart && state == atc_pkg::S_CSUM && good;
  assign reject = take && !restart && state == atc_pkg::S_CSUM && !good;

  assign bcast = (w_dest == atc_pkg::BCAST_ADDR);
  assign res_rad = !bcast ? 8'h00 :
                   (w_rad == 8'h00 || w_rad > max_hop_count) ? max_hop_count : w_rad;

  // Receive sequencer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= atc_pkg::S_IDLE;
    end else if (restart) begin
      state <= atc_pkg::S_LENH;
    end else if (take) begin
      unique case (state)
        atc_pkg::S_IDLE: state <= atc_pkg::S_IDLE;
        atc_pkg::S_LENH: state <= atc_pkg::S_LENL;
        // Empty frame goes straight to checksum
        atc_pkg::S_LENL: begin
          state <= ({len[15:8], bif.data} == 16'h0000) ? atc_pkg::S_CSUM : atc_pkg::S_BODY;
        end
        atc_pkg::S_BODY: begin
          if (cnt + 16'h0001 == len) begin
            state <= atc_pkg::S_CSUM;
          end
        end
        atc_pkg::S_CSUM: state <= atc_pkg::S_IDLE;
        default: state <= atc_pkg::S_IDLE;
      endcase
    end
  end

  // Length, byte count and running sum
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len <= 16'h0000;
      cnt <= 16'h0000;
      sum <= 8'h00;
    end else if (restart) begin
      cnt <= 16'h0000;
      sum <= 8'h00;
    end else if (take) begin
      if (state == atc_pkg::S_LENH) begin
        len[15:8] <= bif.data;
      end
      if (state == atc_pkg::S_LENL) begin
        len[7:0] <= bif.data;
      end
      if (state == atc_pkg::S_BODY) begin
        sum <= sum + bif.data;
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // Field capture by offset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_type <= 8'h00;
      w_id <= 8'h00;
      w_dest <= 64'h0;
      w_sep <= 8'h00;
      w_dep <= 8'h00;
      w_clu <= 16'h0000;
      w_prof <= 16'h0000;
      w_rad <= 8'h00;
      w_opt <= 8'h00;
      w_plen <= 8'h00;
      w_err <= 1'b0;
    end else if (restart) begin
      w_type <= 8'h00;
      w_rad <= 8'h00;
      w_opt <= 8'h00;
      w_plen <= 8'h00;
      w_err <= 1'b0;
    end else if (take && state == atc_pkg::S_LENL && {len[15:8], bif.data} == 16'h0000) begin
      w_err <= 1'b1;
    end else if (take && state == atc_pkg::S_BODY) begin
      // Unknown frame types are dropped
      if (off == atc_pkg::OFF_TYPE) begin
        w_type <= bif.data;
        w_err <= !(bif.data == atc_pkg::FT_TXREQ || bif.data == atc_pkg::FT_EXPL ||
                   bif.data == atc_pkg::FT_REMOTE);
      end
      if (off == atc_pkg::OFF_ID) begin
        w_id <= bif.data;
      end
      if (off >= atc_pkg::OFF_DEST_MSB && off <= atc_pkg::OFF_DEST_LSB) begin
        w_dest <= {w_dest[55:0], bif.data};
      end
      if (w_type == atc_pkg::FT_TXREQ) begin
        if (off == atc_pkg::TX_RAD) begin
          w_rad <= bif.data;
        end
        if (off == atc_pkg::TX_OPT) begin
          w_opt <= bif.data;
        end
      end
      if (w_type == atc_pkg::FT_EXPL) begin
        if (off == atc_pkg::EX_SEP) begin
          w_sep <= bif.data;
        end
        if (off == atc_pkg::EX_DEP) begin
          w_dep <= bif.data;
        end
        if (off == atc_pkg::EX_CLU_H || off == atc_pkg::EX_CLU_L) begin
          w_clu <= {w_clu[7:0], bif.data};
        end
        if (off == atc_pkg::EX_PROF_H || off == atc_pkg::EX_PROF_L) begin
          w_prof <= {w_prof[7:0], bif.data};
        end
        if (off == atc_pkg::EX_RAD) begin
          w_rad <= bif.data;
        end
        if (off == atc_pkg::EX_OPT) begin
          w_opt <= bif.data;
        end
      end
      if (w_type == atc_pkg::FT_REMOTE && off == atc_pkg::RM_OPT) begin
        w_opt <= bif.data;
      end
      if (in_pl) begin
        if (pl_wr) begin
          w_plen <= w_plen + 8'h01;
        end else begin
          w_err <= 1'b1;
        end
      end
    end
  end

  // Result latch on good frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_resp <= 1'b0;
      r_bcast <= 1'b0;
      r_apply <= 1'b0;
      r_type <= 8'h00;
      r_id <= 8'h00;
      r_dest <= 64'h0;
      r_sep <= 8'h00;
      r_dep <= 8'h00;
      r_clu <= 16'h0000;
      r_prof <= 16'h0000;
      r_rad <= 8'h00;
      r_opt <= 8'h00;
      r_plen <= 8'h00;
    end else if (commit) begin
      r_resp <= (w_id != 8'h00);
      r_bcast <= bcast;
      r_apply <= (w_type == atc_pkg::FT_REMOTE) && w_opt[atc_pkg::APPLY_BIT];
      r_type <= w_type;
      r_id <= w_id;
      r_dest <= w_dest;
      r_sep <= (w_type == atc_pkg::FT_EXPL) ? w_sep : default_src_endpoint;
      r_dep <= (w_type == atc_pkg::FT_EXPL) ? w_dep : default_dest_endpoint;
      r_clu <= (w_type == atc_pkg::FT_EXPL) ? w_clu : default_cluster_id;
      r_prof <= (w_type == atc_pkg::FT_EXPL) ? w_prof : 16'h0000;
      r_rad <= res_rad;
      r_opt <= w_opt;
      r_plen <= w_plen;
    end
  end

  // Pending flag, hardware set beats release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending <= 1'b0;
    end else if (commit) begin
      pending <= 1'b1;
    end else if (release_wr) begin
      pending <= 1'b0;
    end
  end

  // Frame event pulses and error count
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_ok_o <= 1'b0;
      frame_bad_o <= 1'b0;
      resp_req_o <= 1'b0;
      err_cnt <= 8'h00;
    end else begin
      frame_ok_o <= commit;
      frame_bad_o <= reject;
      resp_req_o <= commit && (w_id != 8'h00);
      if (reject) begin
        err_cnt <= err_cnt + 8'h01;
      end
    end
  end

  // APB phases
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign rd = acc && !pwrite_i;
  assign release_wr = wr && paddr_i == atc_pkg::REG_CTRL && pwdata_i[atc_pkg::CTRL_REL];
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  assign stat = {r_type, r_id, 6'h00, r_opt[7:6], r_opt[3:0], r_apply, r_bcast, r_resp, pending};

  // Register read map
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      atc_pkg::REG_CTRL: rd_mux = {31'h0, api_escape_mode};
      atc_pkg::REG_HOPS: rd_mux = {24'h0, max_hop_count};
      atc_pkg::REG_MAXPL: rd_mux = {24'h0, max_payload_size};
      atc_pkg::REG_DEFS: rd_mux = {default_cluster_id, default_dest_endpoint, default_src_endpoint};
      atc_pkg::REG_STATUS: rd_mux = stat;
      atc_pkg::REG_DEST_HI: rd_mux = r_dest[63:32];
      atc_pkg::REG_DEST_LO: rd_mux = r_dest[31:0];
      atc_pkg::REG_ADDR: rd_mux = {r_clu, r_dep, r_sep};
      atc_pkg::REG_TXP: rd_mux = {r_prof, r_opt, r_rad};
      atc_pkg::REG_PLEN: rd_mux = {24'h0, r_plen};
      atc_pkg::REG_PDATA: rd_mux = {24'h0, mem_q};
      atc_pkg::REG_ERRCNT: rd_mux = {24'h0, err_cnt};
      default: mapped = 1'b0;
    endcase
  end

  // Read data captured in setup phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      prdata_o <= rd_mux;
    end
  end

  // Writable settings
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      api_escape_mode <= 1'b0;
      max_hop_count <= atc_pkg::HOPS_RST;
      max_payload_size <= atc_pkg::MAXPL_RST;
      default_src_endpoint <= atc_pkg::DEF_EP_RST;
      default_dest_endpoint <= atc_pkg::DEF_EP_RST;
      default_cluster_id <= atc_pkg::DEF_CLU_RST;
    end else if (wr) begin
      if (paddr_i == atc_pkg::REG_CTRL) begin
        api_escape_mode <= pwdata_i[atc_pkg::CTRL_ESC];
      end
      if (paddr_i == atc_pkg::REG_HOPS) begin
        max_hop_count <= pwdata_i[7:0];
      end
      if (paddr_i == atc_pkg::REG_MAXPL) begin
        max_payload_size <= pwdata_i[7:0];
      end
      if (paddr_i == atc_pkg::REG_DEFS) begin
        default_src_endpoint <= pwdata_i[7:0];
        default_dest_endpoint <= pwdata_i[15:8];
        default_cluster_id <= pwdata_i[31:16];
      end
    end
  end

  // Payload pointer: write sets, read advances
  always_comb begin
    next_rd_ptr = rd_ptr;
    if (acc && paddr_i == atc_pkg::REG_PDATA) begin
      next_rd_ptr = pwrite_i ? pwdata_i[7:0] : rd_ptr + 8'h01;
    end
  end

  // Pointer register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr <= 8'h00;
    end else begin
      rd_ptr <= next_rd_ptr;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence csum_take_s;
    take && !restart && state == atc_pkg::S_CSUM;
  endsequence

  csum_bad_a:
    assert property (csum_take_s ##0 (8'(sum + bif.data) != atc_pkg::CSUM_FULL) |=> frame_bad_o && !frame_ok_o)
    else $error("wrong checksum accepted");
  resp_flag_a:
    assert property (csum_take_s ##0 good |=> resp_req_o == ($past(w_id) != 8'h00) && r_resp == resp_req_o)
    else $error("response flag wrong");
  rad_clamp_a:
    assert property (csum_take_s ##0 (good && bcast) |=> r_rad <= $past(max_hop_count))
    else $error("radius above maximum");
  rad_ucast_a:
    assert property (frame_ok_o && !r_bcast |-> r_rad == 8'h00)
    else $error("radius used for unicast");
  rad_zero_a:
    assert property (csum_take_s ##0 (good && bcast && w_rad == 8'h00) |=> r_rad == $past(max_hop_count))
    else $error("zero radius not maximum");
  expl_ep_a:
    assert property (csum_take_s ##0 (good && w_type == atc_pkg::FT_EXPL) |=> r_sep == $past(w_sep)
      && r_clu == $past(w_clu))
    else $error("explicit endpoint lost");
  apply_opt_a:
    assert property (frame_ok_o |-> r_apply == (r_type == atc_pkg::FT_REMOTE && r_opt[atc_pkg::APPLY_BIT]))
    else $error("apply flag wrong");
  opt_map_a:
    assert property (csum_take_s ##0 good |=> r_opt == $past(w_opt) && stat[9:8] == r_opt[7:6]
      && stat[7:4] == r_opt[3:0])
    else $error("option decode wrong");
  bad_hold_a:
    assert property (frame_bad_o |-> !frame_ok_o && pending == $past(pending))
    else $error("bad frame acted on");
endmodule : atc_api_tx_frame_codec
`default_nettype wire

// >>> pkg/atc_pkg.sv
// Contract
// - checksum equals 0xFF minus byte sum
// - escaped mode restores 0x7D-prefixed bytes
// - frame id zero suppresses response
// - radius zero or too big uses max; unicast frames get radius zero
// - explicit frame overrides default endpoints, cluster
// - remote setting applies on apply bit
// - option bits and delivery method decode
package atc_pkg;
  // Framing bytes
  localparam logic [7:0] SOF_BYTE = 8'h7E;
  localparam logic [7:0] ESC_BYTE = 8'h7D;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] CSUM_FULL = 8'hFF;
  // Frame types
  localparam logic [7:0] FT_TXREQ = 8'h10;
  localparam logic [7:0] FT_EXPL = 8'h11;
  localparam logic [7:0] FT_REMOTE = 8'h17;
  // Byte offsets within a frame
  localparam logic [15:0] OFF_TYPE = 16'h0003;
  localparam logic [15:0] OFF_ID = 16'h0004;
  localparam logic [15:0] OFF_DEST_MSB = 16'h0005;
  localparam logic [15:0] OFF_DEST_LSB = 16'h000C;
  localparam logic [15:0] TX_RAD = 16'h000F;
  localparam logic [15:0] TX_OPT = 16'h0010;
  localparam logic [15:0] TX_PL = 16'h0011;
  localparam logic [15:0] EX_SEP = 16'h000F;
  localparam logic [15:0] EX_DEP = 16'h0010;
  localparam logic [15:0] EX_CLU_H = 16'h0011;
  localparam logic [15:0] EX_CLU_L = 16'h0012;
  localparam logic [15:0] EX_PROF_H = 16'h0013;
  localparam logic [15:0] EX_PROF_L = 16'h0014;
  localparam logic [15:0] EX_RAD = 16'h0015;
  localparam logic [15:0] EX_OPT = 16'h0016;
  localparam logic [15:0] EX_PL = 16'h0017;
  localparam logic [15:0] RM_OPT = 16'h000F;
  localparam logic [15:0] RM_PL = 16'h0010;
  localparam logic [15:0] OFF_NONE = 16'hFFFF;
  // Broadcast address and option fields
  localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_FFFF;
  localparam int APPLY_BIT = 1;
  // Payload buffer address width
  localparam int PL_AW = 8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HOPS = 8'h04;
  localparam logic [7:0] REG_MAXPL = 8'h08;
  localparam logic [7:0] REG_DEFS = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_DEST_HI = 8'h14;
  localparam logic [7:0] REG_DEST_LO = 8'h18;
  localparam logic [7:0] REG_ADDR = 8'h1C;
  localparam logic [7:0] REG_TXP = 8'h20;
  localparam logic [7:0] REG_PLEN = 8'h24;
  localparam logic [7:0] REG_PDATA = 8'h28;
  localparam logic [7:0] REG_ERRCNT = 8'h2C;
  // Control fields and reset values
  localparam int CTRL_ESC = 0;
  localparam int CTRL_REL = 1;
  localparam logic [7:0] HOPS_RST = 8'h07;
  localparam logic [7:0] MAXPL_RST = 8'hFF;
  localparam logic [7:0] DEF_EP_RST = 8'h00;
  localparam logic [15:0] DEF_CLU_RST = 16'h0000;
  // Receive states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_LENH = 5'h02,
    S_LENL = 5'h04,
    S_BODY = 5'h08,
    S_CSUM = 5'h10
  } atc_state_t;
endpackage : atc_pkg

// >>> pkg/atc_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
// Unescaped byte stream between decoder and parser
interface atc_byte_if;
  logic [7:0] data;
  logic valid;
  logic sof;
  logic ready;
  modport src (output data, output valid, output sof, input ready);
  modport dst (input data, input valid, input sof, output ready);
endinterface : atc_byte_if
`default_nettype wire

// >>> verilog/atc_esc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module atc_esc_decoder (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic esc_mode_i,
  output logic rx_ready_o,
  atc_byte_if.src out
);
  // Escape prefix seen, next byte is flipped
  logic esc_pend;
  logic is_esc;

  // Prefix byte is swallowed in escaped mode
  assign is_esc = esc_mode_i && !esc_pend && (rx_data_i == atc_pkg::ESC_BYTE);
  assign out.valid = rx_valid_i && !is_esc;
  assign out.data = esc_pend ? (rx_data_i ^ atc_pkg::ESC_XOR) : rx_data_i;
  // A flipped delimiter is data, not a start
  assign out.sof = !esc_pend && (rx_data_i == atc_pkg::SOF_BYTE);
  assign rx_ready_o = out.ready;

  // Escape tracking
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      esc_pend <= 1'b0;
    end else if (!esc_mode_i) begin
      esc_pend <= 1'b0;
    end else if (rx_valid_i && out.ready) begin
      esc_pend <= is_esc;
    end
  end

  sequence esc_taken_s;
    rx_valid_i && out.ready && is_esc;
  endsequence
  sequence next_taken_s;
    rx_valid_i && out.ready && esc_mode_i;
  endsequence

  esc_pair_a:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      esc_taken_s ##1 next_taken_s |-> out.valid && out.data == (rx_data_i ^ atc_pkg::ESC_XOR))
    else $error("escaped byte not restored");
  esc_drop_a:
    assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      esc_taken_s |-> !out.valid ##1 !esc_mode_i || esc_pend)
    else $error("escape prefix passed on");
endmodule : atc_esc_decoder
`default_nettype wire

// >>> verilog/atc_pl_mem.sv
`timescale 1ns/1ps
`default_nettype none
module atc_pl_mem (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [atc_pkg::PL_AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [atc_pkg::PL_AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  // Payload storage
  logic [7:0] mem [0:(1<<atc_pkg::PL_AW)-1];

  // Write port
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : atc_pl_mem
`default_nettype wire

// >>> tb/atc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial port
module atc_host_model (
  input wire logic clk_sys_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  // Line idle at time zero
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // Offer a byte, hold it until taken
  task put(input logic [7:0] b);
    rx_data_o <= b;
    rx_valid_o <= 1'b1;
    do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
  endtask : put
  // Send one frame, checksum optionally spoiled
  task send(input logic esc, input logic [7:0] body[$], input logic spoil);
    logic [7:0] raw[$];
    logic [7:0] sum;
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    raw = {8'h00, 8'(body.size()), body, (8'hFF - sum) ^ {7'h00, spoil}};
    put(8'h7E);
    foreach (raw[i]) begin
      if (esc && (raw[i] inside {8'h7E, 8'h7D, 8'h11, 8'h13})) begin
        put(8'h7D);
        put(raw[i] ^ 8'h20);
      end else begin
        put(raw[i]);
      end
    end
    // Released line shows inverted data
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask : send
endmodule : atc_host_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Clock, reset and bus lines
  logic clk_sys_i;
  logic rst_n_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Serial lines and frame pulses
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic ok;
  logic bad;
  logic resp;
  // Last access and frame results
  logic [31:0] rd;
  logic err_seen;
  logic [2:0] seen;
  logic [7:0] fb[$];
  int fails;
  int check_count;

  atc_api_tx_frame_codec uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .frame_ok_o(ok), .frame_bad_o(bad), .resp_req_o(resp));
  atc_host_model host (.clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid));

  // Free running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Count and report one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer, waits for ready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read and compare masked bits
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  // Frame body from a packed value
  task load(input logic [255:0] v, input int n);
    fb = {};
    for (int i = 0; i < n; i++) fb.push_back(v[8*(n-1-i) +: 8]);
  endtask : load
  // Release, set mode, send, gather pulses
  task frame(input logic esc, input logic spoil);
    apb(1'b1, atc_pkg::REG_CTRL, {30'h0, 1'b1, esc});
    host.send(esc, fb, spoil);
    seen = 3'h0;
    repeat (4) begin
      #1;
      seen = seen | {ok, bad, resp};
      @(posedge clk_sys_i);
    end
  endtask : frame
  // Counts and verdict, ends the run
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    print_verdict();
  end
  // Test sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(atc_pkg::REG_HOPS, 32'hFF, 32'h7);
    rdchk(atc_pkg::REG_MAXPL, 32'hFF, 32'hFF);
    rdchk(atc_pkg::REG_DEFS, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    $display("test reset done");
    load(176'h1001_0013A200400A0127_FFFE_0000_5478446174613041, 22);
    for (int i = 0; i < 2; i++) begin
      frame(i[0], 1'b0);
      chk({29'h0, seen}, 32'h5);
      rdchk(atc_pkg::REG_STATUS, 32'hFFFF_0007, 32'h1001_0003);
      rdchk(atc_pkg::REG_DEST_HI, 32'hFFFF_FFFF, 32'h0013_A200);
      rdchk(atc_pkg::REG_DEST_LO, 32'hFFFF_FFFF, 32'h400A_0127);
      rdchk(atc_pkg::REG_TXP, 32'hFFFF_FFFF, 32'h0);
      rdchk(atc_pkg::REG_PLEN, 32'hFFFF, 32'h8);
      apb(1'b1, atc_pkg::REG_PDATA, 32'h7);
      rdchk(atc_pkg::REG_PDATA, 32'hFF, 32'h41);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, atc_pkg::REG_MAXPL, 32'h7 + i);
      frame(1'b0, 1'b0);
      chk({29'h0, seen}, i ? 32'h5 : 32'h2);
    end
    frame(1'b0, 1'b1);
    chk({29'h0, seen}, 32'h2);
    rdchk(atc_pkg::REG_STATUS, 32'h1, 32'h0);
    rdchk(atc_pkg::REG_ERRCNT, 32'hFF, 32'h2);
    $display("test transmit done");
    apb(1'b1, atc_pkg::REG_DEFS, 32'h1234_5566);
    for (int i = 0; i < 2; i++) begin
      load({144'h1100_000000000000FFFF_FFFE_E82A_0011_C105, i ? 8'h00 : 8'h09, i ? 8'h4F : 8'hC0, 8'h54}, 21);
      apb(1'b1, atc_pkg::REG_HOPS, i ? 32'h0A : 32'h07);
      frame(i[0], 1'b0);
      chk({29'h0, seen}, 32'h4);
      rdchk(atc_pkg::REG_STATUS, 32'hFFFF_03F7, i ? 32'h1100_01F5 : 32'h1100_0305);
      rdchk(atc_pkg::REG_ADDR, 32'hFFFF_FFFF, 32'h0011_2AE8);
      rdchk(atc_pkg::REG_TXP, 32'hFFFF_FFFF, i ? 32'hC105_4F0A : 32'hC105_C007);
    end
    $display("test explicit done");
    for (int i = 0; i < 2; i++) begin
      load({96'h1701_0013A20040401122_FFFE, i ? 8'h00 : 8'h02, 24'h4E4801}, 16);
      frame(1'b0, 1'b0);
      chk({29'h0, seen}, 32'h5);
      rdchk(atc_pkg::REG_STATUS, 32'hFF00_000B, i ? 32'h1700_0003 : 32'h1700_000B);
      rdchk(atc_pkg::REG_ADDR, 32'hFFFF_FFFF, 32'h1234_5566);
    end
    load(32'h0801_4E48, 4);
    frame(1'b0, 1'b0);
    chk({29'h0, seen}, 32'h2);
    rdchk(atc_pkg::REG_ERRCNT, 32'hFF, 32'h3);
    $display("test remote done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
